// ==== src/dac_cfg_regs.sv ====
`timescale 1ns/100ps
`default_nettype none

module dac_cfg_regs (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire logic                 sclkIn,
  input  wire logic                 csIn_n,
  input  wire logic                 sdioIn,
  output logic                      sdioOut,
  output logic                      sdioOe,
  output logic                      sdoOut,
  output logic                      sdoOe,
  input  wire dac_cfg_pkg::status_t statusIn,
  input  wire logic [15:0]          dataIn,
  input  wire logic                 dataValidIn,
  output logic [15:0]               dataOut,
  output logic                      dataValidOut,
  output dac_cfg_pkg::cfg_t         cfgOut,
  output logic                      irqOut
);
  import dac_cfg_pkg::*;

  logic [2:0]  pinS1Q;     // First sync stage: sclk, cs, sdio
  logic [2:0]  pinS2Q;     // Second sync stage
  logic        sclkPrevQ;  // Last synced clock level
  logic        sclkRise;   // Serial clock rising edge
  logic        sclkFall;   // Serial clock falling edge
  logic        csLow;      // Chip select active
  logic        bitIn;      // Synced serial data
  phase_t      phaseQ;     // Transfer phase
  logic [4:0]  cntQ;       // Bits taken in this frame
  logic [7:0]  shiftQ;     // Incoming shift register
  logic [7:0]  shiftNext;  // Shift register with new bit
  logic        readQ;      // Instruction is a read
  logic [6:0]  addrQ;      // Instruction address
  logic [7:0]  rdShiftQ;   // Outgoing read data
  logic        sdoQ;       // Bit driven to the host
  logic        wrStrobe;   // Data byte of a write is complete
  logic [7:0]  commQ;      // Serial communication control
  logic [7:0]  powerQ;     // Power control
  logic [7:0]  formatQ;    // Input data format
  logic [7:0]  irqEnQ;     // Interrupt enables
  logic [7:0]  evQ;        // Latched event flags
  logic [7:0]  evSet;      // Events this cycle
  logic [7:0]  evClr;      // Flags cleared by software
  status_t     statPrevQ;  // Status one cycle ago
  logic        softRst;    // Device held in reset
  logic        irqQ;       // Registered interrupt
  logic [15:0] swapped;    // Input word after bit swap
  logic [7:0]  rdData;     // Readback mux

  // Two-stage synchroniser for the serial pins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pinS1Q    <= 3'h2;  // Idle levels: clock low, select high
      pinS2Q    <= 3'h2;
      sclkPrevQ <= 1'b0;  // Matches idle clock, no false edge
    end else begin
      pinS1Q    <= {sclkIn, csIn_n, sdioIn};
      pinS2Q    <= pinS1Q;
      sclkPrevQ <= pinS2Q[2];
    end
  end

  assign sclkRise = pinS2Q[2] & ~sclkPrevQ;
  assign sclkFall = ~pinS2Q[2] & sclkPrevQ;
  assign csLow    = ~pinS2Q[1];
  assign bitIn    = pinS2Q[0];
  assign softRst  = commQ[COMM_RESET];

  // Shift in the selected bit order
  always_comb begin
    if (commQ[COMM_LSBF]) begin
      shiftNext = {bitIn, shiftQ[7:1]};
    end else begin
      shiftNext = {shiftQ[6:0], bitIn};
    end
  end

  // Readback, undefined bits forced low
  always_comb begin
    unique case (addrQ)
      ADDR_COMM:   rdData = commQ & COMM_MASK;
      ADDR_POWER:  rdData = powerQ & POWER_MASK;
      ADDR_FORMAT: rdData = formatQ & FORMAT_MASK;
      ADDR_IRQEN:  rdData = irqEnQ & IRQEN_MASK;
      ADDR_EVENT:  rdData = evQ & EVENT_MASK;
      default:     rdData = 8'h00;
    endcase
  end

  // Frame sequencer: instruction byte, then one data byte
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phaseQ   <= PH_IDLE;
      cntQ     <= 5'h00;
      shiftQ   <= 8'h00;
      readQ    <= 1'b0;
      addrQ    <= 7'h00;
      rdShiftQ <= 8'h00;
    end else if (!csLow) begin
      phaseQ <= PH_IDLE;
      cntQ   <= 5'h00;
    end else if (sclkRise) begin
      unique case (phaseQ)
        PH_IDLE, PH_INSTR: begin
          shiftQ <= shiftNext;
          cntQ   <= cntQ + 5'h01;
          phaseQ <= PH_INSTR;
          if (cntQ == INSTR_LAST) begin
            readQ    <= shiftNext[7];
            addrQ    <= shiftNext[6:0];
            phaseQ   <= PH_DATA;
            rdShiftQ <= 8'h00;
          end
        end
        PH_DATA: begin
          shiftQ <= shiftNext;
          cntQ   <= cntQ + 5'h01;
          if (cntQ == FRAME_LAST) begin
            phaseQ <= PH_DONE;
          end
        end
        PH_DONE: begin
          phaseQ <= PH_DONE;
        end
      endcase
    end else if (phaseQ == PH_DATA && cntQ == INSTR_LAST + 5'h01 &&
                 pinS2Q[2]) begin
      // Load read data once the address is known
      rdShiftQ <= rdData;
    end else if (sclkFall && phaseQ == PH_DATA) begin
      if (commQ[COMM_LSBF]) begin
        rdShiftQ <= {1'b0, rdShiftQ[7:1]};
      end else begin
        rdShiftQ <= {rdShiftQ[6:0], 1'b0};
      end
    end
  end

  assign wrStrobe = csLow & sclkRise & (phaseQ == PH_DATA) &
                    (cntQ == FRAME_LAST) & ~readQ;

  // Read bit changes on falling serial clock edges
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sdoQ <= 1'b0;
    end else if (sclkFall && phaseQ == PH_DATA) begin
      sdoQ <= commQ[COMM_LSBF] ? rdShiftQ[0] : rdShiftQ[7];
    end
  end

  // Read data on SDIO only when bidirectional, else on SDO
  assign sdioOut = sdoQ;
  assign sdoOut  = sdoQ;
  assign sdioOe  = csLow & readQ & (phaseQ == PH_DATA) &
                   commQ[COMM_BIDIR];
  assign sdoOe   = csLow & readQ & (phaseQ == PH_DATA) &
                   ~commQ[COMM_BIDIR];

  // Communication register, never cleared by its own reset bit
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      commQ <= COMM_RST;
    end else if (wrStrobe && addrQ == ADDR_COMM) begin
      commQ <= shiftNext & COMM_MASK;
    end
  end

  // Configuration registers held at defaults during soft reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      powerQ  <= POWER_RST;
      formatQ <= FORMAT_RST;
      irqEnQ  <= IRQEN_RST;
    end else if (softRst) begin
      powerQ  <= POWER_RST;
      formatQ <= FORMAT_RST;
      irqEnQ  <= IRQEN_RST;
    end else if (wrStrobe) begin
      if (addrQ == ADDR_POWER) begin
        powerQ <= shiftNext & POWER_MASK;
      end
      if (addrQ == ADDR_FORMAT && shiftNext[1:0] != WIDTH_BAD) begin
        formatQ <= shiftNext & FORMAT_MASK;
      end
      if (addrQ == ADDR_IRQEN) begin
        irqEnQ <= shiftNext & IRQEN_MASK;
      end
    end
  end

  // Event detection from status edges and levels
  always_comb begin
    evSet               = 8'h00;
    evSet[EV_PLL_LOST]  = statPrevQ.pllLocked & ~statusIn.pllLocked;
    evSet[EV_PLL_LOCK]  = statusIn.pllLocked & ~statPrevQ.pllLocked;
    evSet[EV_SYNC_LOST] = statPrevQ.syncLocked & ~statusIn.syncLocked;
    evSet[EV_SYNC_LOCK] = statusIn.syncLocked & ~statPrevQ.syncLocked;
    evSet[EV_FIFO1]     = statusIn.fifoWarn1;
    evSet[EV_FIFO2]     = statusIn.fifoWarn2;
    evClr = (wrStrobe && addrQ == ADDR_EVENT) ? shiftNext : 8'h00;
  end

  // Previous status for edge detection
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      statPrevQ <= '0;
    end else begin
      statPrevQ <= statusIn;
    end
  end

  // Sticky flags; write one clears, a new event wins over the clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      evQ <= EVENT_RST;
    end else if (softRst) begin
      evQ <= EVENT_RST;
    end else begin
      evQ <= ((evQ & ~evClr) | evSet) & EVENT_MASK;
    end
  end

  // Interrupt from any enabled flag
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irqQ <= 1'b0;
    end else begin
      irqQ <= |(evQ & irqEnQ);
    end
  end

  assign irqOut = irqQ;

  // Optional reversal of input port bit order
  always_comb begin
    swapped = dataIn;
    if (formatQ[FMT_SWAP]) begin
      for (int i = 0; i < 16; i++) begin
        swapped[i] = dataIn[15 - i];
      end
    end
  end

  // Receiver output: offset binary turned to twos complement
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dataOut      <= 16'h0000;
      dataValidOut <= 1'b0;
    end else if (powerQ[PWR_RX] || softRst) begin
      dataValidOut <= 1'b0;
    end else begin
      dataValidOut <= dataValidIn;
      if (dataValidIn) begin
        dataOut <= {swapped[15] ^ formatQ[FMT_BINARY], swapped[14:0]};
      end
    end
  end

  // Decoded configuration; pairing order passed to receiver
  always_comb begin
    cfgOut.sdioBidir    = commQ[COMM_BIDIR];
    cfgOut.lsbFirst     = commQ[COMM_LSBF];
    cfgOut.softReset    = softRst;
    cfgOut.pdI          = powerQ[PWR_I];
    cfgOut.pdQ          = powerQ[PWR_Q];
    cfgOut.pdRx         = powerQ[PWR_RX];
    cfgOut.pdAux        = powerQ[PWR_AUX];
    cfgOut.offsetBinary = formatQ[FMT_BINARY];
    cfgOut.qFirst       = formatQ[FMT_QFIRST];
    cfgOut.msbSwap      = formatQ[FMT_SWAP];
    cfgOut.busWidth     = formatQ[1:0];
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_SDIO_DIR: assert property (sdioOe |-> commQ[COMM_BIDIR] && readQ)
    else $error("SDIO driven while input only");
  AST_SOFT_RESET: assert property (softRst |=> powerQ == POWER_RST)
    else $error("Power register not held during soft reset");
  AST_PD_I: assert property (wrStrobe && addrQ == ADDR_POWER && !softRst
      |=> cfgOut.pdI == $past(shiftNext[PWR_I]))
    else $error("I channel power down not updated");
  AST_PD_Q: assert property (wrStrobe && addrQ == ADDR_POWER && !softRst
      |=> cfgOut.pdQ == $past(shiftNext[PWR_Q]))
    else $error("Q channel power down not updated");
  AST_RX_OFF: assert property (powerQ[PWR_RX] |=> !dataValidOut)
    else $error("Receiver produced data while powered down");
  AST_AUX_RST: assert property (softRst ##1 softRst |-> cfgOut.pdAux)
    else $error("Aux ADC not powered down at default");
  AST_WIDTH_OK: assert property (cfgOut.busWidth != WIDTH_BAD)
    else $error("Invalid bus width stored");
  AST_IRQ_PLL_LOST: assert property (evQ[EV_PLL_LOST] && irqEnQ[EV_PLL_LOST]
      |=> irqOut)
    else $error("Enabled lock lost flag gave no interrupt");
  AST_LATCH_LOST: assert property (evQ[EV_PLL_LOST] && !evClr[EV_PLL_LOST]
      && !softRst |=> evQ[EV_PLL_LOST])
    else $error("Lock lost flag did not stay latched");
  AST_IRQ_QUIET: assert property (!(|(evQ & irqEnQ)) |=> !irqOut)
    else $error("Interrupt with no enabled flag");
  AST_RSVD_ZERO: assert property ((commQ & ~COMM_MASK) == 8'h00
      && (formatQ & ~FORMAT_MASK) == 8'h00)
    else $error("Undefined bit set");

  COV_WRITE: cover property (wrStrobe && addrQ == ADDR_POWER);
  COV_READ_BIDIR: cover property (sdioOe ##1 sdioOe);
  COV_IRQ: cover property (!irqOut ##1 irqOut);

endmodule

`default_nettype wire

// ==== src/dac_cfg_pkg.sv ====
`default_nettype none

package dac_cfg_pkg;

  // Register addresses, seven bits of the instruction byte
  localparam logic [6:0] ADDR_COMM   = 7'h00;
  localparam logic [6:0] ADDR_POWER  = 7'h01;
  localparam logic [6:0] ADDR_FORMAT = 7'h03;
  localparam logic [6:0] ADDR_IRQEN  = 7'h04;
  localparam logic [6:0] ADDR_EVENT  = 7'h06;

  // Reset values
  localparam logic [7:0] COMM_RST   = 8'h00;
  localparam logic [7:0] POWER_RST  = 8'h10;
  localparam logic [7:0] FORMAT_RST = 8'h00;
  localparam logic [7:0] IRQEN_RST  = 8'h00;
  localparam logic [7:0] EVENT_RST  = 8'h00;

  // Implemented bits; all others read zero and drop writes
  localparam logic [7:0] COMM_MASK   = 8'he0;
  localparam logic [7:0] POWER_MASK  = 8'hf0;
  localparam logic [7:0] FORMAT_MASK = 8'he3;
  localparam logic [7:0] IRQEN_MASK  = 8'hf3;
  localparam logic [7:0] EVENT_MASK  = 8'hf3;

  // Field positions
  localparam int COMM_BIDIR   = 7;
  localparam int COMM_LSBF    = 6;
  localparam int COMM_RESET   = 5;
  localparam int PWR_I        = 7;
  localparam int PWR_Q        = 6;
  localparam int PWR_RX       = 5;
  localparam int PWR_AUX      = 4;
  localparam int FMT_BINARY   = 7;
  localparam int FMT_QFIRST   = 6;
  localparam int FMT_SWAP     = 5;
  localparam int EV_PLL_LOST  = 7;
  localparam int EV_PLL_LOCK  = 6;
  localparam int EV_SYNC_LOST = 5;
  localparam int EV_SYNC_LOCK = 4;
  localparam int EV_FIFO1     = 1;
  localparam int EV_FIFO2     = 0;

  // Receiver bus width codes
  localparam logic [1:0] WIDTH_WORD   = 2'b00;
  localparam logic [1:0] WIDTH_BYTE   = 2'b01;
  localparam logic [1:0] WIDTH_NIBBLE = 2'b10;
  localparam logic [1:0] WIDTH_BAD    = 2'b11;

  // Serial frame: instruction byte then one data byte
  localparam logic [4:0] INSTR_LAST = 5'h07;
  localparam logic [4:0] FRAME_LAST = 5'h0f;

  // Decoded configuration handed to the rest of the device
  typedef struct packed {
    logic       sdioBidir;
    logic       lsbFirst;
    logic       softReset;
    logic       pdI;
    logic       pdQ;
    logic       pdRx;
    logic       pdAux;
    logic       offsetBinary;
    logic       qFirst;
    logic       msbSwap;
    logic [1:0] busWidth;
  } cfg_t;

  // Live status levels from PLL, sync logic and FIFO
  typedef struct packed {
    logic pllLocked;
    logic syncLocked;
    logic fifoWarn1;
    logic fifoWarn2;
  } status_t;

  // Serial transfer phase
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_INSTR = 2'b01,
    PH_DATA  = 2'b10,
    PH_DONE  = 2'b11
  } phase_t;

endpackage

`default_nettype wire

// ==== bench/spi_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// Host controller on the serial control port, instruction byte and one data byte per frame
module spi_host_model (
  input  wire logic clk_sys,   // System clock used as time base
  input  wire logic sdioWire,  // Resolved level of the shared data pin
  input  wire logic sdoIn,     // Separate read data pin
  output logic      sclkOut,   // Serial clock, still outside frames
  output logic      csOut_n,   // Chip select, active low
  output logic      sdioDrv    // Host value offered to the data pin
);
  import dac_cfg_pkg::*;

  localparam int HALF = 6;  // Clocks per serial phase, margin over three
  logic lsbMode   = 1'b0;   // Bit order the device now expects
  logic bidirMode = 1'b0;   // Read data comes back on the shared pin

  // Idle levels at time zero
  initial begin
    sclkOut = 1'b0;
    csOut_n = 1'b1;
    sdioDrv = 1'b0;
  end

  // Wait a number of system clocks
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One frame: instruction byte then one data byte
  task automatic xfer(input logic rd, input logic [6:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    logic [7:0] ins;
    int         k;
    int         pos;
    ins   = {rd, addr};
    rdata = 8'h00;
    @(posedge clk_sys);
    csOut_n <= 1'b0;
    waitClk(HALF);
    for (k = 0; k < 16; k++) begin
      // Bit order follows the last written mode
      pos = lsbMode ? (k % 8) : 7 - (k % 8);
      if (k < 8) begin
        sdioDrv <= ins[pos];
      end else if (!rd) begin
        sdioDrv <= wdata[pos];
      end else begin
        // Released: offer a changing value so stale data cannot pass
        sdioDrv <= ~sdioDrv;
      end
      waitClk(HALF);
      // Read bits are taken where they have long settled
      if (rd && k >= 8) begin
        rdata[pos] = bidirMode ? sdioWire : sdoIn;
      end
      sclkOut <= 1'b1;
      waitClk(HALF);
      sclkOut <= 1'b0;
    end
    waitClk(HALF);
    csOut_n <= 1'b1;
    waitClk(HALF);
    // New port modes apply from the next frame
    if (!rd && addr == ADDR_COMM) begin
      lsbMode   = wdata[COMM_LSBF];
      bidirMode = wdata[COMM_BIDIR];
    end
  endtask
endmodule

`default_nettype wire

// ==== bench/dac_device_config_registers_test.sv ====
`timescale 1ns/100ps
`default_nettype none

// Counts a comparison and reports a mismatch
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    nErrors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end

module dac_device_config_registers_test;
  import dac_cfg_pkg::*;

  logic        clk_sys = 1'b0;  // 40 MHz system clock
  logic        reset_n = 1'b0;  // Asynchronous reset, active low
  logic        sclk;            // Serial clock from host
  logic        csLine_n;        // Chip select from host
  logic        sdioDrv;         // Host value for the data pin
  wire logic   sdioWire;        // Resolved data pin
  wire logic   sdoWire;         // Separate pin, wrong level when released
  logic        sdioOut;         // Device read data on the data pin
  logic        sdioOe;          // Device drives the data pin
  logic        sdoOut;          // Device read data on separate pin
  logic        sdoOe;           // Device drives separate pin
  status_t     statusIn = '0;   // Live status levels
  logic [15:0] dataIn = 16'h0003;
  logic        dataValidIn = 1'b1;
  logic [15:0] dataOut;
  logic        dataValidOut;
  cfg_t        cfgOut;
  logic        irqOut;
  int          nErrors = 0;     // Mismatches seen
  int          compares = 0;    // Comparisons made

  // Wire level from the device's enables; host value on the data pin otherwise
  assign sdioWire = sdioOe ? sdioOut : sdioDrv;
  assign sdoWire  = sdoOe ? sdoOut : ~sdoOut;

  // Clock generator
  always #12.5 clk_sys = ~clk_sys;

  dac_cfg_regs dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .sclkIn(sclk),
    .csIn_n(csLine_n), .sdioIn(sdioWire), .sdioOut(sdioOut),
    .sdioOe(sdioOe), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .statusIn(statusIn), .dataIn(dataIn), .dataValidIn(dataValidIn),
    .dataOut(dataOut), .dataValidOut(dataValidOut), .cfgOut(cfgOut),
    .irqOut(irqOut)
  );

  spi_host_model host (
    .clk_sys(clk_sys), .sdioWire(sdioWire), .sdoIn(sdoWire),
    .sclkOut(sclk), .csOut_n(csLine_n), .sdioDrv(sdioDrv)
  );

  // Let clock edges pass, then step off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Register write
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer(1'b0, a, d, r);
    settle(1);
  endtask

  // Register read and compare
  task automatic rdChk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    host.xfer(1'b1, a, 8'h00, r);
    `CHK(r, e)
  endtask

  // Ends the run with the counts and the verdict
  task automatic giveVerdict;
    $display("errors=%0d compares=%0d", nErrors, compares);
    if (nErrors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Values after reset, unmapped address
  task automatic testReset;
    `CHK(cfgOut, 12'h020)
    rdChk(ADDR_COMM, 8'h00);
    rdChk(ADDR_POWER, 8'h10);
    rdChk(ADDR_FORMAT, 8'h00);
    rdChk(ADDR_IRQEN, 8'h00);
    rdChk(7'h02, 8'h00);
  endtask

  // Power-down bits and the receiver gate
  task automatic testPower;
    wr(ADDR_POWER, 8'hff);
    rdChk(ADDR_POWER, 8'hf0);
    `CHK({cfgOut.pdI, cfgOut.pdQ, cfgOut.pdRx, cfgOut.pdAux}, 4'hf)
    `CHK(dataValidOut, 1'b0)
    wr(ADDR_POWER, 8'h00);
    settle(2);
    `CHK({cfgOut.pdI, cfgOut.pdQ, cfgOut.pdRx, cfgOut.pdAux}, 4'h0)
    `CHK(dataValidOut, 1'b1)
  endtask

  // Bus widths, invalid width, swap, encoding, pairing order
  task automatic testFormat;
    int i;
    for (i = 0; i < 3; i++) begin
      wr(ADDR_FORMAT, {6'h00, i[1:0]});
      `CHK(cfgOut.busWidth, i[1:0])
    end
    wr(ADDR_FORMAT, 8'h43);
    rdChk(ADDR_FORMAT, 8'h02);
    wr(ADDR_FORMAT, 8'h20);
    settle(2);
    `CHK(dataOut, 16'hc000)
    wr(ADDR_FORMAT, 8'h80);
    settle(2);
    `CHK(dataOut, 16'h8003)
    wr(ADDR_FORMAT, 8'h5d);
    `CHK(cfgOut.qFirst, 1'b1)
    rdChk(ADDR_FORMAT, 8'h41);
    wr(ADDR_FORMAT, 8'h00);
  endtask

  // Status step then a few clocks of hold
  task automatic stat(input status_t v);
    @(posedge clk_sys);
    statusIn <= v;
    settle(4);
  endtask

  // Sticky flags, each enable alone, clearing
  task automatic testEvents;
    int         k;
    logic [7:0] b;
    stat(4'b1000);
    stat(4'b0000);
    stat(4'b0100);
    stat(4'b0000);
    stat(4'b0010);
    stat(4'b0000);
    stat(4'b0001);
    stat(4'b0000);
    rdChk(ADDR_EVENT, 8'hf3);
    `CHK(irqOut, 1'b0)
    for (k = 0; k < 8; k++) begin
      b = 8'h01 << k;
      if ((b & EVENT_MASK) != 8'h00) begin
        wr(ADDR_IRQEN, b);
        settle(3);
        `CHK(irqOut, 1'b1)
        wr(ADDR_EVENT, b);
        settle(3);
        `CHK(irqOut, 1'b0)
      end
    end
    rdChk(ADDR_EVENT, 8'h00);
    wr(ADDR_IRQEN, 8'h00);
  endtask

  // Soft reset holds defaults until written low
  task automatic testSoftReset;
    wr(ADDR_POWER, 8'h80);
    wr(ADDR_COMM, 8'h20);
    settle(2);
    `CHK({cfgOut.softReset, cfgOut.pdI, dataValidOut}, 3'b100)
    wr(ADDR_POWER, 8'h40);
    rdChk(ADDR_POWER, 8'h10);
    wr(ADDR_COMM, 8'h00);
    `CHK(cfgOut.softReset, 1'b0)
    wr(ADDR_POWER, 8'h40);
    rdChk(ADDR_POWER, 8'h40);
    wr(ADDR_POWER, 8'h10);
  endtask

  // Shared data pin and least significant bit first
  task automatic testBidirLsb;
    wr(ADDR_COMM, 8'hc0);
    `CHK({cfgOut.sdioBidir, cfgOut.lsbFirst}, 2'b11)
    wr(ADDR_IRQEN, 8'h12);
    rdChk(ADDR_IRQEN, 8'h12);
    wr(ADDR_COMM, 8'h00);
    rdChk(ADDR_IRQEN, 8'h12);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    settle(4);
    testReset();
    testPower();
    testFormat();
    testEvents();
    testSoftReset();
    testBidirLsb();
    giveVerdict();
  end

  // Watchdog well above the expected run length
  initial begin
    #(40000 * 25);
    nErrors++;
    giveVerdict();
  end
endmodule

`default_nettype wire
